// ==== rtl/serial_adc_pkg.sv ====
package serial_adc_pkg;

  // Result and frame layout.
  localparam int RESULT_W = 12;
  localparam int LEAD_ZEROS = 4;
  localparam int FRAME_BITS = LEAD_ZEROS + RESULT_W;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [CNT_W-1:0] FIRST_BIT = 4'h0;

  // Conversion timing at the 125 MHz system clock.
  localparam int SYS_CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 6000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 10;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

  // Result buffer depth.
  localparam int FIFO_DEPTH = 4;

  // One conversion result as delivered by the converter core.
  typedef struct packed {
    logic [RESULT_W-1:0] code;
  } result_word_t;

  // Observable state of the readout logic.
  typedef struct packed {
    logic conv_busy;
    logic read_active;
    logic load_pending;
    logic overrun;
  } readout_status_t;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/100ps
// Two-stage synchroniser for asynchronous pin levels.
module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // pin_sync

// ==== rtl/result_fifo.sv ====
`timescale 1ns/100ps
// Small synchronous FIFO with valid/ready on both sides.
module result_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Full and empty come straight from the fill count.
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Storage is written only on a push, so no reset is needed for it.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap explicitly at DEPTH-1, so depths that are not powers of two also work.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule // result_fifo

// ==== rtl/serial_adc_result_readout.sv ====
`timescale 1ns/100ps
module serial_adc_result_readout #(
  parameter int FIFO_DEPTH = serial_adc_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Serial link pins
  input wire logic ser_clk,
  input wire logic conv_start_n,
  output logic ser_dout,
  output logic ser_dout_oe,
  // Results from the converter core
  input wire logic res_valid,
  output logic res_ready,
  input wire serial_adc_pkg::result_word_t res_data,
  // Status
  output serial_adc_pkg::readout_status_t status
);

  localparam int RW = serial_adc_pkg::RESULT_W;
  localparam int FW = serial_adc_pkg::FRAME_BITS;
  localparam int CW = serial_adc_pkg::CNT_W;

  logic [1:0] pins_s;
  logic sclk_d;
  logic cst_d;
  logic conv_busy;
  logic [serial_adc_pkg::CONV_CNT_W-1:0] conv_cnt;
  logic [RW-1:0] hold;
  logic pending;
  logic [RW-1:0] out_reg;
  logic [CW-1:0] bit_cnt;
  logic reading;
  logic spent;
  logic overrun;
  logic [FW-1:0] shreg;
  logic fifo_valid;
  serial_adc_pkg::result_word_t fifo_data;

  // The serial clock is not a clock here: it is sampled like any pin.
  pin_sync #(.W(2)) u_pin_sync (
    .clk(sys_clk),
    .arst_n(arst_n),
    .d({ser_clk, ~conv_start_n}),
    .q(pins_s)
  );

  // Edge detection on the synchronised pin levels.
  // Convert-start passes the synchroniser inverted, so its reset level matches the idle high pin.
  // Without this a false fall and rise would follow every reset and start a phantom conversion.
  wire sclk_s = pins_s[1];
  wire cst_s = ~pins_s[0];
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire conv_fall = ~cst_s & cst_d;
  wire conv_rise = cst_s & ~cst_d;
  wire conv_reset = conv_fall & ~sclk_s;
  wire eoc = conv_busy & (conv_cnt == serial_adc_pkg::CONV_LAST);
  wire take = eoc & fifo_valid;
  wire load_now = pending & (~reading | conv_reset);
  wire frame_start = sclk_rise & (bit_cnt == serial_adc_pkg::FIRST_BIT);
  wire frame_end = sclk_fall & (reading | overrun) & (bit_cnt == serial_adc_pkg::LAST_BIT);
  wire [FW-1:0] frame_word = {{serial_adc_pkg::LEAD_ZEROS{1'b0}}, out_reg};

  // Results wait in the buffer; it drains only at conversion ends, so the core sees back-pressure.
  result_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data.code),
    .out_valid(fifo_valid),
    .out_ready(eoc),
    .out_data(fifo_data.code)
  );

  // Previous pin levels for edge detection.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d <= 1'b0;
      cst_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cst_d <= cst_s;
    end
  end

  // Conversion timer; a new rising edge restarts it.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_busy <= 1'b0;
      conv_cnt <= '0;
    end else if (conv_rise) begin
      conv_busy <= 1'b1;
      conv_cnt <= '0;
    end else if (conv_busy) begin
      conv_busy <= ~eoc;
      conv_cnt <= conv_cnt + 1'b1;
    end
  end

  // A new result sets the pending flag; the set wins over a load in the same cycle.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= '0;
      pending <= 1'b0;
    end else if (take) begin
      hold <= fifo_data.code;
      pending <= 1'b1;
    end else if (load_now) begin
      pending <= 1'b0;
    end
  end

  // Output register follows the held result whenever no read blocks it.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= '0;
    end else if (load_now) begin
      out_reg <= hold;
    end
  end

  // Frame state; pauses with the clock low simply leave everything still.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= '0;
      reading <= 1'b0;
      spent <= 1'b0;
      overrun <= 1'b0;
    end else if (conv_reset) begin
      bit_cnt <= '0;
      reading <= 1'b0;
      spent <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (frame_start & spent) begin
        overrun <= 1'b1;
      end else if (frame_start & ~overrun) begin
        reading <= 1'b1;
      end
      if (sclk_fall & (reading | overrun)) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
      if (frame_end & reading) begin
        reading <= 1'b0;
        spent <= 1'b1;
      end
    end
  end

  // Shifter and pin driver; the first rising edge of a frame takes a fresh copy.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= '0;
      ser_dout <= 1'b0;
      ser_dout_oe <= 1'b0;
    end else if (conv_reset) begin
      shreg <= '0;
      ser_dout <= 1'b0;
      ser_dout_oe <= 1'b0;
    end else if (frame_start) begin
      shreg <= {frame_word[FW-2:0], 1'b0};
      ser_dout <= frame_word[FW-1];
      ser_dout_oe <= 1'b1;
    end else if (sclk_rise) begin
      shreg <= {shreg[FW-2:0], 1'b0};
      ser_dout <= shreg[FW-1];
    end else if (frame_end & ~overrun & ~spent) begin
      ser_dout_oe <= 1'b0;
    end
  end

  // Status is a plain view of internal flags.
  assign status.conv_busy = conv_busy;
  assign status.read_active = reading;
  assign status.load_pending = pending;
  assign status.overrun = overrun;

  // Checks on the readout logic.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_dout_on_rise: assert property ($changed(ser_dout) && !$past(conv_reset) |-> $past(sclk_rise))
    else $error("data output changed without a serial clock rise");
  a_lead_zero: assert property (frame_start |=> !ser_dout && ser_dout_oe)
    else $error("frame did not open with a zero bit");
  a_msb_fifth: assert property (sclk_rise && bit_cnt == 4'h4 && reading |=> ser_dout == out_reg[RW-1])
    else $error("result MSB not in fifth bit position");
  a_release_16th: assert property (frame_end && reading && !overrun && !conv_reset |=> !ser_dout_oe)
    else $error("data output not released on sixteenth falling edge");
  a_overrun_drive: assert property (overrun && !conv_reset |=> ser_dout_oe)
    else $error("data output released after extra pulses");
  a_conv_reset: assert property (conv_reset |=> bit_cnt == '0 && !reading && !ser_dout_oe)
    else $error("convert-start fall did not reset the counter");
  a_reset_high_sclk: assert property (conv_fall && sclk_s && reading |=> reading)
    else $error("reset taken while serial clock high");
  a_idle_load: assert property (pending && !reading && !take |=> !pending && out_reg == $past(hold))
    else $error("idle output register not loaded");
  a_defer_load: assert property (reading && !conv_reset |=> $stable(out_reg))
    else $error("output register changed during a read");
  a_forced_load: assert property (conv_reset && pending && reading |=> out_reg == $past(hold))
    else $error("convert-start fall did not force the load");
  a_conv_time: assert property (conv_rise ##1 !conv_rise [*8] |-> conv_busy)
    else $error("conversion ended too early");
  a_eoc_count: assert property (eoc && !conv_rise |-> conv_cnt == serial_adc_pkg::CONV_LAST ##1 !conv_busy)
    else $error("conversion end at wrong count");
  a_count_step: assert property (sclk_fall && reading && !conv_reset |=> bit_cnt == $past(bit_cnt) + 1'b1)
    else $error("bit counter did not advance");

  c_full_read: cover property (frame_end && reading);
  c_overrun: cover property (frame_start && spent);
  c_deferred: cover property (take && reading);
  c_forced: cover property (conv_reset && pending && reading);

endmodule // serial_adc_result_readout

// ==== sim/link_host.sv ====
`timescale 1ns/100ps
// Host master of the link: it makes the serial clock only within reads.
module link_host (
  // Link pins
  output logic ser_clk,
  output logic conv_start_n,
  input wire logic ser_dout,
  input wire logic ser_dout_oe
);
  logic last_bit;
  wire logic data_line;
  // A released line shows the inverse of its last bit, so stale data never reads as good.
  assign data_line = ser_dout_oe ? ser_dout : ~last_bit;
  // The clock rests low outside reads and convert-start rests high.
  initial begin
    ser_clk = 1'b0;
    conv_start_n = 1'b1;
    last_bit = 1'b0;
  end
  // Pulses of 32 ns every 64 ns; each bit is taken at the falling edge, and a pause between calls keeps the clock low.
  task automatic clock_bits(input int n, output logic [31:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      #32 ser_clk = 1'b1;
      #32 ser_clk = 1'b0;
      got = {got[30:0], data_line};
      last_bit = data_line;
    end
  endtask
  // Convert-start pulse with the serial clock held low throughout.
  task automatic conv_pulse(input int low_ns);
    conv_start_n = 1'b0;
    #(low_ns) conv_start_n = 1'b1;
  endtask
endmodule // link_host

// ==== sim/serial_adc_result_readout_tb_top.sv ====
`timescale 1ns/100ps
module serial_adc_result_readout_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic res_valid = 1'b0;
  serial_adc_pkg::result_word_t res_data = '0;
  logic ser_clk, conv_start_n, ser_dout, ser_dout_oe, res_ready;
  serial_adc_pkg::readout_status_t status;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] got;
  logic [31:0] got2;

  // The host model owns the serial clock and convert-start.
  link_host host (.ser_clk(ser_clk), .conv_start_n(conv_start_n), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe));
  serial_adc_result_readout dut (.sys_clk(sys_clk), .arst_n(arst_n), .ser_clk(ser_clk),
    .conv_start_n(conv_start_n), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .status(status));

  // System clock of 8 ns.
  always #4 sys_clk = ~sys_clk;

  // The run needs about 7000 cycles, so a hang is cut short well beyond that.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Offer one result; it is taken at the rising edge after a falling edge that saw room.
  task automatic push(input logic [11:0] d);
    @(negedge sys_clk);
    res_valid = 1'b1;
    res_data.code = d;
    while (res_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    res_valid = 1'b0;
  endtask

  task automatic read_frame(input logic [15:0] exp);
    host.clock_bits(16, got);
    chk("frame", exp, got[15:0]);
    #40;
    chk("oe after frame", 16'h0, {15'h0, ser_dout_oe});
  endtask

  task automatic t_fill_drain();
    logic [11:0] w [4] = '{12'hA5C, 12'h3F0, 12'h001, 12'hFFF};
    foreach (w[i]) push(w[i]);
    @(negedge sys_clk);
    chk("res_ready full", 16'h0, {15'h0, res_ready});
    foreach (w[i]) begin
      host.conv_pulse(96);
      #6200;
      read_frame({4'h0, w[i]});
    end
    chk("res_ready drained", 16'h1, {15'h0, res_ready});
  endtask

  task automatic t_paused_read();
    push(12'h6B2);
    host.conv_pulse(96);
    #6200;
    host.clock_bits(8, got);
    #496;
    host.clock_bits(8, got2);
    chk("bytes", {4'h0, 12'h6B2}, {got[7:0], got2[7:0]});
  endtask

  task automatic t_deferred();
    push(12'h19D);
    host.conv_pulse(96);
    #5904;
    host.clock_bits(8, got);
    #40;
    chk("pending", 16'h1, {15'h0, status.load_pending});
    host.clock_bits(8, got2);
    chk("old frame", {4'h0, 12'h6B2}, {got[7:0], got2[7:0]});
    #40;
    chk("loaded", 16'h0, {15'h0, status.load_pending});
    host.conv_pulse(96);
    read_frame({4'h0, 12'h19D});
  endtask

  task automatic t_overrun_forced();
    host.clock_bits(20, got);
    chk("restart", {4'h0, 12'h19D}, got[19:4]);
    chk("restart zeros", 16'h0, {12'h0, got[3:0]});
    #40;
    chk("oe kept", 16'h3, {14'h0, ser_dout_oe, status.overrun});
    push(12'hC37);
    host.conv_pulse(96);
    #40;
    chk("oe cleared", 16'h1, {14'h0, ser_dout_oe, status.conv_busy});
    #5904;
    host.clock_bits(4, got);
    #296;
    chk("pending", 16'h1, {15'h0, status.load_pending});
    host.conv_pulse(1600);
    read_frame({4'h0, 12'hC37});
  endtask

  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    chk("reset state", 16'h0001, {10'h0, status, ser_dout_oe, res_ready});
    repeat (4) @(negedge sys_clk);
    t_fill_drain();
    t_paused_read();
    t_deferred();
    t_overrun_forced();
    complete_run();
  end
endmodule // serial_adc_result_readout_tb_top
